// *** src/ebac_defs.svh ***
// Constants for the data EEPROM byte access controller.
`ifndef EBAC_DEFS_SVH
`define EBAC_DEFS_SVH
`define EBAC_ADDR_W        9
`define EBAC_DEPTH         512
`define EBAC_READ_STALL    3'h4
`define EBAC_PROG_STALL    3'h2
`define EBAC_UNLOCK_CYC    3'h4
`define EBAC_MODE_ATOMIC   2'h0
`define EBAC_MODE_ERASE    2'h1
`define EBAC_MODE_WRITE    2'h2
`define EBAC_MODE_RSVD     2'h3
`define EBAC_ERASED        8'hFF
`define EBAC_T_ATOMIC_US   3400
`define EBAC_T_SPLIT_US    1800
`define EBAC_OSC_MHZ       8
`define EBAC_CTRL_MODE_LO  4
`define EBAC_CTRL_IRQEN    3
`define EBAC_CTRL_UNLOCK   2
`define EBAC_CTRL_GO       1
`define EBAC_CTRL_READ     0
`endif

// *** src/ebac_pkg.sv ***
// Types for the data EEPROM byte access controller.
package ebac_pkg;
  typedef enum logic [1:0] {
    EBAC_IDLE  = 2'h0,
    EBAC_ERASE = 2'h1,
    EBAC_WRITE = 2'h3
  } ebac_state_t;
  typedef logic [1:0] ebac_mode_t;
endpackage

// *** src/ebac_osc_timer.sv ***
// Programming time counter run from the calibrated oscillator tick.
`timescale 1ns/10ps
`include "ebac_defs.svh"
module ebac_osc_timer #(
  parameter int OSC_MHZ = `EBAC_OSC_MHZ,
  parameter int T_SPLIT = `EBAC_T_SPLIT_US * OSC_MHZ,
  parameter int T_FULL  = `EBAC_T_ATOMIC_US * OSC_MHZ
)(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  input  wire logic osc_tick,
  input  wire logic start,
  input  wire logic full_time,
  output logic      done
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        done_r;
  logic        done_nxt;

  // Counts oscillator ticks; the CPU clock only samples them.
  always_comb
  begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (start)
    begin
      cnt_nxt = full_time ? 16'(T_FULL) : 16'(T_SPLIT);
      run_nxt = 1'b1;
    end
    else if (run_r && osc_tick)
    begin
      if (cnt_r <= 16'h0001)
      begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
      cnt_nxt = cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      // A running count survives reset so the operation completes.
      if (run_r)
      begin
        cnt_r  <= cnt_nxt;
        run_r  <= run_nxt;
        done_r <= done_nxt;
      end
      else
      begin
        cnt_r  <= 16'h0000;
        run_r  <= 1'b0;
        done_r <= 1'b0;
      end
    end
    else if (clk_en)
    begin
      cnt_r  <= cnt_nxt;
      run_r  <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule

// *** src/ebac_ctrl.sv ***
// Data EEPROM byte access controller: registers, unlock, stall and array.
//
// Functional notes
// - Byte-wide array of 128, 256 or 512 bytes.
// - Address, data, control are CPU I/O locations.
// - Read stalls CPU four clock cycles.
// - Programming start stalls CPU two cycles.
// - Mode zero, unlocked go: erase then write.
// - Go bit stays set as busy until done.
// - No read or program while busy.
// - Mode 01: erase the addressed byte only.
// - Mode 10: write data without erase.
// - Program time counted from oscillator ticks.
// - Reset does not abort running programming.
// - Unlock clears itself after four cycles.
// - Times 3.4 ms atomic, 1.8 ms split.
// - Mode writes ignored while busy.
// - Ready interrupt level when enabled and ready.
`timescale 1ns/10ps
`include "ebac_defs.svh"
module ebac_ctrl
  import ebac_pkg::*;
#(
  parameter int DEPTH   = `EBAC_DEPTH,
  parameter int AW      = `EBAC_ADDR_W,
  parameter int OSC_MHZ = `EBAC_OSC_MHZ
)(
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  input  wire logic            clk_en,
  input  wire logic            osc_tick,
  input  wire logic            global_irq_en,
  input  wire logic            addr_wr,
  input  wire logic [AW-1:0]   addr_wdata,
  input  wire logic            data_wr,
  input  wire logic [7:0]      data_wdata,
  input  wire logic            ctrl_wr,
  input  wire logic [7:0]      ctrl_wdata,
  output logic      [AW-1:0]   nv_byte_address,
  output logic      [7:0]      nv_byte_data,
  output logic      [7:0]      nv_control,
  output logic                 cpu_stall,
  output logic                 ready_irq
);
  import ebac_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]          mem_r [DEPTH];
  logic [AW-1:0]       addr_r, addr_nxt;
  logic [7:0]          data_r, data_nxt;
  ebac_mode_t          mode_r, mode_nxt;
  logic                irqen_r, irqen_nxt;
  logic                go_r, go_nxt;
  logic [2:0]          unl_r, unl_nxt;
  logic [2:0]          stall_r, stall_nxt;
  logic                stall_on_r;
  logic                unl_on_r;
  ebac_state_t         st_r, st_nxt;
  logic                irq_r, irq_nxt;
  logic                tmr_start;
  logic                tmr_done;
  logic                mem_we;
  logic [7:0]          mem_wd;
  logic [AW-1:0]       wa;

  function automatic logic ctl_bit(input logic [7:0] v, input int b);
    return v[b];
  endfunction

  ebac_osc_timer #(.OSC_MHZ(OSC_MHZ)) u_tmr (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .osc_tick  (osc_tick),
    .start     (tmr_start),
    .full_time (mode_r == `EBAC_MODE_ATOMIC),
    .done      (tmr_done)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    mode_nxt  = mode_r;
    irqen_nxt = irqen_r;
    go_nxt    = go_r;
    unl_nxt   = (unl_r != 3'h0) ? unl_r - 3'h1 : 3'h0;
    stall_nxt = (stall_r != 3'h0) ? stall_r - 3'h1 : 3'h0;
    st_nxt    = st_r;
    tmr_start = 1'b0;
    mem_we    = 1'b0;
    mem_wd    = data_r;
    wa        = addr_r;
    if (addr_wr && !go_r)
      addr_nxt = addr_wdata;
    if (data_wr)
      data_nxt = data_wdata;
    if (ctrl_wr)
    begin
      irqen_nxt = ctl_bit(ctrl_wdata, `EBAC_CTRL_IRQEN);
      if (!go_r)
        mode_nxt = ctrl_wdata[`EBAC_CTRL_MODE_LO +: 2];
      if (ctl_bit(ctrl_wdata, `EBAC_CTRL_UNLOCK))
        unl_nxt = `EBAC_UNLOCK_CYC;
      if (ctl_bit(ctrl_wdata, `EBAC_CTRL_READ) && !go_r)
      begin
        data_nxt  = mem_r[addr_r];
        stall_nxt = `EBAC_READ_STALL;
      end
      else if (ctl_bit(ctrl_wdata, `EBAC_CTRL_GO) && !go_r
               && unl_r != 3'h0
               && mode_r != `EBAC_MODE_RSVD)
      begin
        go_nxt    = 1'b1;
        tmr_start = 1'b1;
        stall_nxt = `EBAC_PROG_STALL;
        unl_nxt   = 3'h0;
        st_nxt    = (mode_r == `EBAC_MODE_WRITE) ? EBAC_WRITE
                                                 : EBAC_ERASE;
      end
    end
    case (st_r)
      EBAC_ERASE:
        if (tmr_done)
        begin
          mem_we = 1'b1;
          mem_wd = `EBAC_ERASED;
          if (mode_r == `EBAC_MODE_ATOMIC)
          begin
            mem_wd = data_r;
          end
          go_nxt = 1'b0;
          st_nxt = EBAC_IDLE;
        end
      EBAC_WRITE:
        if (tmr_done)
        begin
          mem_we = 1'b1;
          mem_wd = mem_r[addr_r] & data_r;
          go_nxt = 1'b0;
          st_nxt = EBAC_IDLE;
        end
      default:
        st_nxt = st_nxt;
    endcase
    irq_nxt = irqen_r && global_irq_en && !go_nxt;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      irqen_r    <= 1'b0;
      unl_r      <= 3'h0;
      stall_r    <= 3'h0;
      irq_r      <= 1'b0;
      stall_on_r <= 1'b0;
      unl_on_r   <= 1'b0;
      // A running operation keeps its address, data and mode to the end.
      if (go_r)
      begin
        go_r <= go_nxt;
        st_r <= st_nxt;
      end
      else
      begin
        addr_r <= '0;
        mode_r <= `EBAC_MODE_ATOMIC;
        data_r <= 8'h00;
        go_r   <= 1'b0;
        st_r   <= EBAC_IDLE;
      end
    end
    else if (clk_en)
    begin
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
      mode_r  <= mode_nxt;
      irqen_r <= irqen_nxt;
      go_r    <= go_nxt;
      unl_r   <= unl_nxt;
      stall_r <= stall_nxt;
      st_r    <= st_nxt;
      irq_r   <= irq_nxt;
      stall_on_r <= (stall_nxt != 3'h0);
      unl_on_r   <= (unl_nxt != 3'h0);
    end
  end

  // Array cells keep content through reset, as nonvolatile storage.
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && mem_we)
      mem_r[wa] <= mem_wd;
  end

  assign nv_byte_address = addr_r;
  assign nv_byte_data    = data_r;
  assign nv_control      = {2'b00, mode_r, irqen_r, unl_on_r,
                            go_r, 1'b0};
  assign cpu_stall       = stall_on_r;
  assign ready_irq       = irq_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b || !clk_en);

  a_read_stall: assert property (
    ctrl_wr && ctrl_wdata[0] && !go_r |=> cpu_stall [*4] ##1 !cpu_stall
  ) else $error("read stall not four cycles");
  a_prog_stall: assert property (
    $rose(go_r) |-> cpu_stall ##1 cpu_stall ##1 !cpu_stall
  ) else $error("program stall not two cycles");
  a_unlock_close: assert property (
    $rose(nv_control[2]) |-> ##[1:4] !nv_control[2]
  ) else $error("unlock window too long");
  a_go_needs_unlock: assert property (
    !go_r ##1 go_r |-> $past(unl_r) != 3'h0
  ) else $error("program began without unlock");
  a_mode_frozen: assert property (
    go_r && $past(go_r) |-> $stable(mode_r)
  ) else $error("mode changed while busy");
  a_addr_frozen: assert property (
    go_r && $past(go_r) |-> $stable(addr_r)
  ) else $error("address changed while busy");
  a_rsvd_idle: assert property (
    !go_r && mode_r == 2'h3 |=> !go_r
  ) else $error("reserved mode started an operation");
  a_irq_level: assert property (
    irqen_r && global_irq_en && !go_r |=> ready_irq || go_r
  ) else $error("ready interrupt missing");
  a_busy_done: assert property (
    $fell(go_r) |-> $past(tmr_done)
  ) else $error("busy cleared before time elapsed");

  c_read: cover property (ctrl_wr && ctrl_wdata[0] && !go_r);
  c_atomic: cover property ($rose(go_r) && mode_r == 2'h0);
  c_erase: cover property ($fell(go_r) && mode_r == 2'h1);
  c_write: cover property ($fell(go_r) && mode_r == 2'h2);
endmodule

// *** testbench/tb_eeprom_byte_access_controller.sv ***
// Self-checking testbench for the data EEPROM byte access controller.
`timescale 1ns/10ps
`include "ebac_defs.svh"
module tb_eeprom_byte_access_controller;
  logic       ref_clk    = 1'b0;
  logic       rst_b      = 1'b0;
  logic       irq_global = 1'b0;
  logic       ce         = 1'b1;
  logic       a_wr       = 1'b0;
  logic       d_wr       = 1'b0;
  logic       c_wr       = 1'b0;
  logic [8:0] a_wd       = 9'h000;
  logic [7:0] d_wd       = 8'h00;
  logic [7:0] c_wd       = 8'h00;
  logic [8:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] ctrl_q;
  logic       stall;
  logic       irq;
  int         err_total  = 0;
  int         checked    = 0;

  always #5 ref_clk = ~ref_clk;

  // Oscillator ticks every cycle; with OSC_MHZ at 1 a microsecond is a tick.
  ebac_ctrl #(.OSC_MHZ(1)) uut (
    .ref_clk         (ref_clk),
    .rst_b           (rst_b),
    .clk_en          (ce),
    .osc_tick        (1'b1),
    .global_irq_en   (irq_global),
    .addr_wr         (a_wr),
    .addr_wdata      (a_wd),
    .data_wr         (d_wr),
    .data_wdata      (d_wd),
    .ctrl_wr         (c_wr),
    .ctrl_wdata      (c_wd),
    .nv_byte_address (addr_q),
    .nv_byte_data    (data_q),
    .nv_control      (ctrl_q),
    .cpu_stall       (stall),
    .ready_irq       (irq)
  );

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Kind 0 writes the address, 1 the data, 2 the control register.
  task automatic put(input int k, input logic [8:0] v);
    @(posedge ref_clk);
    a_wr <= (k == 0);
    d_wr <= (k == 1);
    c_wr <= (k == 2);
    a_wd <= v;
    d_wd <= v[7:0];
    c_wd <= v[7:0];
    @(posedge ref_clk);
    a_wr <= 1'b0;
    d_wr <= 1'b0;
    c_wr <= 1'b0;
    #1;
  endtask

  task automatic stalls(output int n);
    n = 0;
    repeat (8)
    begin
      if (stall === 1'b1)
        n++;
      cyc(1);
    end
  endtask

  task automatic prog(input logic [1:0] m, input logic [7:0] d,
                      input int tt, input bit rs);
    int n;
    int t;
    put(0, 9'h1A5);
    put(1, {1'b0, d});
    put(2, {3'h0, m, 4'h0});
    put(2, {3'h0, m, 4'h4});
    put(2, {3'h0, m, 4'h2});
    stalls(n);
    chk("prog stall", 9'h002, 9'(n));
    chk("busy set", 9'h001, {8'h00, ctrl_q[1]});
    t = 18;
    if (rs)
    begin
      @(posedge ref_clk);
      rst_b <= 1'b0;
      @(posedge ref_clk);
      rst_b <= 1'b1;
      #1;
      t = 20;
      chk("busy after reset", 9'h001, {8'h00, ctrl_q[1]});
    end
    put(2, 9'h001);
    stalls(n);
    chk("read while busy", 9'h000, 9'(n));
    chk("mode held", {7'h00, m}, {7'h00, ctrl_q[5:4]});
    while (ctrl_q[1] !== 1'b0)
    begin
      t++;
      if (t > 5000)
      begin
        chk("busy timeout", 9'h000, 9'h001);
        wrap_up();
      end
      cyc(1);
    end
    chk("prog time", 9'h001, {8'h00, t >= tt - 2 && t <= tt + 4});
  endtask

  task automatic rd(input logic [7:0] e);
    int n;
    put(0, 9'h1A5);
    put(2, 9'h001);
    chk("read data", {1'b0, e}, {1'b0, data_q});
    stalls(n);
    chk("read stall", 9'h004, 9'(n));
  endtask

  task automatic refuse;
    put(2, 9'h004);
    chk("unlock open", 9'h001, {8'h00, ctrl_q[2]});
    cyc(4);
    chk("unlock closed", 9'h000, {8'h00, ctrl_q[2]});
    put(2, 9'h002);
    chk("late go", 9'h000, {8'h00, ctrl_q[1]});
    put(2, 9'h034);
    put(2, 9'h032);
    chk("reserved go", 9'h000, {8'h00, ctrl_q[1]});
  endtask

  // Clock enable low must hold the unlock countdown where it stands.
  task automatic freeze;
    put(2, 9'h004);
    @(posedge ref_clk);
    ce <= 1'b0;
    cyc(6);
    chk("unlock frozen", 9'h001, {8'h00, ctrl_q[2]});
    @(posedge ref_clk);
    ce <= 1'b1;
    cyc(5);
    chk("unlock resumed", 9'h000, {8'h00, ctrl_q[2]});
  endtask

  task automatic irq_chk;
    put(2, 9'h008);
    @(posedge ref_clk);
    irq_global <= 1'b1;
    cyc(2);
    chk("irq on", 9'h001, {8'h00, irq});
    @(posedge ref_clk);
    irq_global <= 1'b0;
    cyc(2);
    chk("irq off", 9'h000, {8'h00, irq});
  endtask

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk("control reset", 9'h000, {1'b0, ctrl_q});
    chk("stall reset", 9'h000, {8'h00, stall});
    prog(`EBAC_MODE_ATOMIC, 8'h3C, 3400, 1'b0);
    rd(8'h3C);
    prog(`EBAC_MODE_ERASE, 8'h00, 1800, 1'b1);
    rd(`EBAC_ERASED);
    prog(`EBAC_MODE_WRITE, 8'h96, 1800, 1'b0);
    rd(8'h96);
    refuse();
    rd(8'h96);
    freeze();
    irq_chk();
    wrap_up();
  end
endmodule
